// >>> fdc_device.sv
// One depth-cascadable 18-bit synchronous FIFO device with APB control
module fdc_device
  import fdc_pkg::*;
(
  input  logic                 pclk,                // System clock, write and read side
  input  logic                 presetn,             // Asynchronous reset, active low
  input  logic                 psel,                // APB select
  input  logic                 penable,             // APB enable
  input  logic                 pwrite,              // APB direction
  input  logic [7:0]           paddr,               // APB byte address
  input  logic [31:0]          pwdata,              // APB write data
  output logic [31:0]          prdata,              // APB read data
  output logic                 pready,              // APB ready
  output logic                 pslverr,             // APB error on unmapped address
  input  logic [`FDC_DW-1:0]   data_in,             // Write data
  input  logic                 write_en_n,          // Write enable, active low
  input  logic                 read_en_n,           // Read enable, active low
  input  logic                 offset_load,         // Low selects offset registers
  input  logic                 replay_pulse,        // Rewind read pointer, standalone only
  input  logic                 first_device_select, // Strap, low marks the first device
  input  logic                 write_token_in,      // Write token from previous device
  input  logic                 read_token_in,       // Read token from previous device
  output logic [`FDC_DW-1:0]   data_out,            // Read data
  output logic                 full_flag_n,         // Device full, active low
  output logic                 empty_flag_n,        // Device empty, active low
  output logic                 almost_empty_flag,   // At or below empty offset
  output logic                 almost_full_flag,    // At or above full threshold
  output logic                 half_full_flag,      // Half full, standalone only
  output logic                 write_token_out,     // Write token to next device
  output logic                 read_token_out,      // Read token to next device
  output logic                 irq                  // Level interrupt
);
  fdc_state_t q, d;

  logic [`FDC_DW-1:0] mem_rdata;
  logic               wr_own, rd_own, wr_req, rd_req, ofs_wr_go, ofs_rd_go;
  logic               wr_go, rd_go, acc, wr_fire;
  logic [`FDC_IW-1:0] ev;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  fdc_mem u_mem (
    .pclk  (pclk),
    .we    (wr_go),
    .waddr (q.wr_ptr),
    .wdata (data_in),
    .re    (rd_go),
    .raddr (q.rd_ptr),
    .rdata (mem_rdata)
  );

  // Strobes are formed on the live inputs; the ring of devices shares pclk
  always_comb begin
    // In a chain a non-first device waits for a token from its neighbour
    wr_own  = !q.cascade || (q.wr_tok == FDC_TOK_OWN);
    rd_own  = !q.cascade || (q.rd_tok == FDC_TOK_OWN);
    wr_req  = q.armed && offset_load && !write_en_n;
    rd_req  = q.armed && offset_load && !read_en_n;
    ofs_wr_go = q.armed && !offset_load && !write_en_n;
    ofs_rd_go = q.armed && !offset_load && !read_en_n;
    wr_go   = wr_req && wr_own && q.full_n;
    rd_go   = rd_req && rd_own && q.empty_n;
    acc     = psel && penable && !q.pready;
    wr_fire = psel && penable && pwrite && q.pready;
  end

  always_comb begin
    d = q;
    ev = '0;
    // Strap passes two flops, then is caught once after reset release
    d.strap_s = {q.strap_s[0], first_device_select};
    if (!q.armed) begin
      if (q.init_cnt == `FDC_STRAP_WAIT) begin
        d.armed  = 1'b1;
        d.first  = !q.strap_s[1];
        d.wr_tok = !q.strap_s[1] ? FDC_TOK_OWN : FDC_TOK_IDLE;
        d.rd_tok = !q.strap_s[1] ? FDC_TOK_OWN : FDC_TOK_IDLE;
      end else begin
        d.init_cnt = q.init_cnt + 2'h1;
      end
    end

    // Token passing: leaving the last location hands ownership on
    d.wto = q.cascade && wr_go && (q.wr_ptr == `FDC_LAST);
    d.rto = q.cascade && rd_go && (q.rd_ptr == `FDC_LAST);
    if (d.wto) begin
      d.wr_tok = FDC_TOK_IDLE;
    end
    if (d.rto) begin
      d.rd_tok = FDC_TOK_IDLE;
    end
    // Inputs come only from the previous device, so no filtering here; the ring closes externally
    if (q.armed && q.cascade && write_token_in && q.wr_tok == FDC_TOK_IDLE) begin
      d.wr_tok = FDC_TOK_OWN;
    end
    if (q.armed && q.cascade && read_token_in && q.rd_tok == FDC_TOK_IDLE) begin
      d.rd_tok = FDC_TOK_OWN;
    end

    // Data path
    if (wr_go) begin
      d.wr_ptr = q.wr_ptr + 1'b1;
      if (q.wr_ptr == `FDC_LAST) begin
        d.wrapped = 1'b1;
      end
    end
    if (rd_go) begin
      d.rd_ptr = q.rd_ptr + 1'b1;
    end
    d.count = q.count + {{(`FDC_CW-1){1'b0}}, wr_go} - {{(`FDC_CW-1){1'b0}}, rd_go};
    // Replay assumes no more than one depth of writes since reset
    if (!q.cascade && replay_pulse) begin
      d.rd_ptr = '0;
      d.count  = q.wrapped ? `FDC_DEPTH : {1'b0, q.wr_ptr};
    end

    // Offset registers: the same low load line is seen by every device
    if (ofs_wr_go) begin
      if (q.ofs_wsel) begin
        d.ofs_f = data_in[`FDC_OW-1:0];
      end else begin
        d.ofs_e = data_in[`FDC_OW-1:0];
      end
      d.ofs_wsel = !q.ofs_wsel;
    end
    d.rd_src = FDC_SRC_NONE;
    if (rd_go) begin
      d.rd_src = FDC_SRC_FIFO;
    end else if (ofs_rd_go) begin
      d.rd_src   = FDC_SRC_OFS;
      d.ofs_rd   = q.ofs_rsel ? q.ofs_f : q.ofs_e;
      d.ofs_rsel = !q.ofs_rsel;
    end
    unique case (q.rd_src)
      FDC_SRC_NONE: d.data_out = q.data_out;
      FDC_SRC_FIFO: d.data_out = mem_rdata;
      FDC_SRC_OFS:  d.data_out = {{(`FDC_DW-`FDC_OW){1'b0}}, q.ofs_rd};
    endcase

    // Per-device flags; the composites are an external OR and so only approximate
    d.full_n  = (d.count != `FDC_DEPTH);
    d.empty_n = (d.count != '0);
    d.ae = ({5'h00, d.count} <= d.ofs_e);
    d.af = ({5'h00, d.count} + d.ofs_f >= {5'h00, `FDC_DEPTH});
    // In a chain the half-full pin is held low; the write token leaves on its own pin
    d.half = !q.cascade && (d.count > (`FDC_DEPTH >> 1));

    // APB register file
    d.pready  = acc;
    d.pslverr = 1'b0;
    if (acc) begin
      d.prdata  = '0;
      d.pslverr = !(hit(paddr, `FDC_REG_CTRL) || hit(paddr, `FDC_REG_STAT) ||
                    hit(paddr, `FDC_REG_OFS) || hit(paddr, `FDC_REG_IRQ_ST) ||
                    hit(paddr, `FDC_REG_IRQ_EN) || hit(paddr, `FDC_REG_IRQ_CLR));
      if (hit(paddr, `FDC_REG_CTRL)) begin
        d.prdata[`FDC_CTRL_CASC] = q.cascade;
      end
      if (hit(paddr, `FDC_REG_STAT)) begin
        d.prdata[6:0] = {q.first, rd_own, wr_own, q.af, q.ae, !q.empty_n, !q.full_n};
        d.prdata[`FDC_ST_CNT_LSB +: `FDC_CW] = q.count;
      end
      if (hit(paddr, `FDC_REG_OFS)) begin
        d.prdata[`FDC_OW-1:0] = q.ofs_e;
        d.prdata[`FDC_OFS_F_LSB +: `FDC_OW] = q.ofs_f;
      end
      if (hit(paddr, `FDC_REG_IRQ_ST)) begin
        d.prdata[`FDC_IW-1:0] = q.irq_st;
      end
      if (hit(paddr, `FDC_REG_IRQ_EN)) begin
        d.prdata[`FDC_IW-1:0] = q.irq_en;
      end
    end
    if (wr_fire && hit(paddr, `FDC_REG_CTRL)) begin
      d.cascade = pwdata[`FDC_CTRL_CASC];
    end
    // A pin load in the same cycle wins over software
    if (wr_fire && hit(paddr, `FDC_REG_OFS) && !ofs_wr_go) begin
      d.ofs_e = pwdata[`FDC_OW-1:0];
      d.ofs_f = pwdata[`FDC_OFS_F_LSB +: `FDC_OW];
    end
    if (wr_fire && hit(paddr, `FDC_REG_IRQ_EN)) begin
      d.irq_en = pwdata[`FDC_IW-1:0];
    end
    if (wr_fire && hit(paddr, `FDC_REG_IRQ_CLR)) begin
      d.irq_st = q.irq_st & ~pwdata[`FDC_IW-1:0];
    end

    // Events are ORed after the clear so a coincident event is kept
    ev[`FDC_IRQ_FULL]  = q.full_n && !d.full_n;
    ev[`FDC_IRQ_EMPTY] = q.empty_n && !d.empty_n;
    ev[`FDC_IRQ_WTOK]  = d.wto;
    ev[`FDC_IRQ_RTOK]  = d.rd_tok == FDC_TOK_OWN && q.rd_tok == FDC_TOK_IDLE && q.armed;
    ev[`FDC_IRQ_WREF]  = wr_req && wr_own && !q.full_n;
    ev[`FDC_IRQ_RREF]  = rd_req && rd_own && !q.empty_n;
    d.irq_st = d.irq_st | ev;
    d.irq    = |(d.irq_st & d.irq_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q         <= '0;
      q.cascade <= `FDC_CTRL_RST;
      q.wr_tok  <= FDC_TOK_IDLE;
      q.rd_tok  <= FDC_TOK_IDLE;
      q.ofs_e   <= `FDC_OFS_E_RST;
      q.ofs_f   <= `FDC_OFS_F_RST;
      q.rd_src  <= FDC_SRC_NONE;
      q.full_n  <= 1'b1;
      q.ae      <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata            = q.prdata;
  assign pready            = q.pready;
  assign pslverr           = q.pslverr;
  assign data_out          = q.data_out;
  assign full_flag_n       = q.full_n;
  assign empty_flag_n      = q.empty_n;
  assign almost_empty_flag = q.ae;
  assign almost_full_flag  = q.af;
  assign half_full_flag    = q.half;
  assign write_token_out   = q.wto;
  assign read_token_out    = q.rto;
  assign irq               = q.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_last_write;
    q.cascade && wr_go && q.wr_ptr == `FDC_LAST;
  endsequence
  sequence s_token_pulse(sig);
    sig ##1 !sig;
  endsequence

  a_full_blocks_write: assert property (!full_flag_n |-> !wr_go)
    else $error("write accepted while full");
  a_empty_blocks_read: assert property (!empty_flag_n |-> !rd_go)
    else $error("read accepted while empty");
  a_fill_sets_full: assert property (wr_go && !rd_go && q.count == `FDC_DEPTH - 7'h01 |=> !full_flag_n)
    else $error("full flag missed");
  a_drain_sets_empty: assert property (rd_go && !wr_go && q.count == 7'h01 |=> !empty_flag_n)
    else $error("empty flag missed");
  a_write_token_pass: assert property (s_last_write |=> s_token_pulse(write_token_out) and q.wr_tok == FDC_TOK_IDLE)
    else $error("write token not passed");
  a_read_token_pass: assert property (q.cascade && rd_go && q.rd_ptr == `FDC_LAST |=> s_token_pulse(read_token_out))
    else $error("read token not passed");
  a_token_wakes: assert property (q.armed && q.cascade && write_token_in && q.wr_tok == FDC_TOK_IDLE
                                  |=> q.wr_tok == FDC_TOK_OWN)
    else $error("write token not taken");
  a_no_half_full: assert property (q.cascade && $past(q.cascade) |-> !half_full_flag)
    else $error("half full shown in cascade");
  a_offset_pair: assert property (ofs_wr_go && !q.ofs_wsel ##1 ofs_wr_go |=> q.ofs_f == $past(data_in[11:0])
                                  && q.ofs_e == $past(data_in[11:0], 2))
    else $error("offset load order wrong");
  a_replay_ignored: assert property (q.cascade && replay_pulse && !rd_go |=> $stable(q.rd_ptr))
    else $error("replay acted in cascade");
  a_first_owns: assert property ($rose(q.armed) |-> q.wr_tok == (q.first ? FDC_TOK_OWN : FDC_TOK_IDLE))
    else $error("wrong start owner");
endmodule // fdc_device

// >>> fdc_mem.sv
// Storage array of one FIFO device with registered read data
module fdc_mem
  import fdc_pkg::*;
(
  input  logic                 pclk,     // System clock
  input  logic                 we,       // Write strobe
  input  logic [`FDC_AW-1:0]   waddr,    // Write address
  input  logic [`FDC_DW-1:0]   wdata,    // Write data
  input  logic                 re,       // Read strobe
  input  logic [`FDC_AW-1:0]   raddr,    // Read address
  output logic [`FDC_DW-1:0]   rdata     // Read data, one edge after re
);
  logic [`FDC_DW-1:0] mem [0:(1<<`FDC_AW)-1];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule // fdc_mem

// >>> fdc_params.svh
// Constants for the depth-cascade FIFO device: sizes, offsets, resets, bit positions
`ifndef FDC_PARAMS_SVH
`define FDC_PARAMS_SVH

`define FDC_DW            18
`define FDC_AW            6
`define FDC_DEPTH         7'h40
`define FDC_LAST          6'h3F
`define FDC_CW            7
`define FDC_OW            12
`define FDC_OFS_E_RST     12'h007
`define FDC_OFS_F_RST     12'h007
`define FDC_STRAP_WAIT    2'h2

`define FDC_REG_CTRL      8'h00
`define FDC_REG_STAT      8'h04
`define FDC_REG_OFS       8'h08
`define FDC_REG_IRQ_ST    8'h0C
`define FDC_REG_IRQ_EN    8'h10
`define FDC_REG_IRQ_CLR   8'h14

`define FDC_CTRL_CASC     0
`define FDC_CTRL_RST      1'h1
`define FDC_OFS_F_LSB     16

`define FDC_IW            6
`define FDC_IRQ_FULL      0
`define FDC_IRQ_EMPTY     1
`define FDC_IRQ_WTOK      2
`define FDC_IRQ_RTOK      3
`define FDC_IRQ_WREF      4
`define FDC_IRQ_RREF      5

`define FDC_ST_CNT_LSB    16

`endif

// >>> fdc_pkg.sv
// Types shared by the depth-cascade FIFO device
package fdc_pkg;
  `include "fdc_params.svh"

  typedef enum logic [1:0] {
    FDC_TOK_IDLE = 2'b01,
    FDC_TOK_OWN  = 2'b10
  } fdc_tok_t;

  typedef enum logic [2:0] {
    FDC_SRC_NONE = 3'b001,
    FDC_SRC_FIFO = 3'b010,
    FDC_SRC_OFS  = 3'b100
  } fdc_src_t;

  typedef struct packed {
    logic [1:0]             strap_s;
    logic [1:0]             init_cnt;
    logic                   armed;
    logic                   first;
    logic                   cascade;
    fdc_tok_t               wr_tok;
    fdc_tok_t               rd_tok;
    logic [`FDC_AW-1:0]     wr_ptr;
    logic [`FDC_AW-1:0]     rd_ptr;
    logic                   wrapped;
    logic [`FDC_CW-1:0]     count;
    logic [`FDC_OW-1:0]     ofs_e;
    logic [`FDC_OW-1:0]     ofs_f;
    logic                   ofs_wsel;
    logic                   ofs_rsel;
    fdc_src_t               rd_src;
    logic [`FDC_OW-1:0]     ofs_rd;
    logic [`FDC_DW-1:0]     data_out;
    logic                   full_n;
    logic                   empty_n;
    logic                   ae;
    logic                   af;
    logic                   half;
    logic                   wto;
    logic                   rto;
    logic [`FDC_IW-1:0]     irq_st;
    logic [`FDC_IW-1:0]     irq_en;
    logic                   irq;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
  } fdc_state_t;
endpackage

// >>> fdc_ring_model.sv
// Stand-in for the rest of the token ring: hands each token back after a delay
module fdc_ring_model (
  input  logic       pclk,            // System clock
  input  logic       presetn,         // Reset, active low
  input  logic [3:0] dly,             // Ring delay in cycles, at least 1
  input  logic       write_token_out, // Write token leaving the device
  input  logic       read_token_out,  // Read token leaving the device
  output logic       write_token_in,  // Write token coming back
  output logic       read_token_in    // Read token coming back
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wcnt_q;
  logic [3:0] rcnt_q;

  // Tokens are one-cycle pulses that idle low, like a neighbour's registered output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcnt_q         <= 4'h0;
      rcnt_q         <= 4'h0;
      write_token_in <= 1'b0;
      read_token_in  <= 1'b0;
    end else begin
      write_token_in <= (wcnt_q == 4'h1);
      read_token_in  <= (rcnt_q == 4'h1);
      if (write_token_out) wcnt_q <= dly;
      else if (wcnt_q != 4'h0) wcnt_q <= wcnt_q - 4'h1;
      if (read_token_out) rcnt_q <= dly;
      else if (rcnt_q != 4'h0) rcnt_q <= rcnt_q - 4'h1;
    end
  end
endmodule // fdc_ring_model

// >>> tb_fdc_device.sv
// Testbench for one FIFO device strapped as first in a two-party token ring
`include "fdc_params.svh"
module tb_fdc_device;
  timeunit 1ns;
  timeprecision 1ns;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, r;
  logic [`FDC_DW-1:0] data_in, data_out;
  logic               write_en_n, read_en_n, offset_load, irq, replay;
  logic               full_flag_n, empty_flag_n, almost_empty_flag, almost_full_flag, half_full_flag;
  logic               write_token_out, read_token_out, write_token_in, read_token_in;
  logic [3:0]         dly;
  logic [11:0]        oe, of;
  logic [`FDC_DW-1:0] q[$];
  int                 fails = 0, n_compared = 0, seed, n_wto = 0, n_rto = 0;

  fdc_device fdc_device_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .data_in, .write_en_n, .read_en_n, .offset_load, .replay_pulse(replay),
    .first_device_select(1'b0), .write_token_in, .read_token_in, .data_out, .full_flag_n,
    .empty_flag_n, .almost_empty_flag, .almost_full_flag, .half_full_flag, .write_token_out,
    .read_token_out, .irq);
  fdc_ring_model fdc_ring_model_inst (.pclk, .presetn, .dly, .write_token_out, .read_token_out,
    .write_token_in, .read_token_in);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (write_token_out === 1'b1) n_wto++;
    if (read_token_out === 1'b1) n_rto++;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // APB master: holds the request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("apb ready", 32'h1, 32'h0);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One-cycle enable pulse; also used for requests the device must refuse
  task automatic poke(input logic rd);
    @(posedge pclk);
    if (rd) read_en_n <= 1'b0;
    else write_en_n <= 1'b0;
    data_in <= $random(seed);
    @(posedge pclk);
    read_en_n <= 1'b1;
    write_en_n <= 1'b1;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    give_verdict();
  end

  initial begin
    logic [`FDC_DW-1:0] w;
    seed = 14105;
    {presetn, psel, penable, pwrite, paddr, pwdata, data_in} = '0;
    {write_en_n, read_en_n, offset_load} = 3'h7;
    dly = 4'h5;
    replay = 1'b0;
    @(posedge pclk);
    #1;
    chk("reset flags", 32'hA0, {full_flag_n, empty_flag_n, almost_empty_flag, almost_full_flag,
      half_full_flag, write_token_out, read_token_out, irq});
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, `FDC_REG_STAT, 32'h0);
    chk("stat after reset", 32'h70, r & 32'h007F_0070);
    apb(1'b0, `FDC_REG_CTRL, 32'h0);
    chk("ctrl cascade", 32'h1, r & 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    apb(1'b1, `FDC_REG_IRQ_EN, 32'h3F);
    apb(1'b0, `FDC_REG_IRQ_EN, 32'h0);
    chk("irq enable", 32'h3F, r);
    $display("test registers done");
    oe = $random(seed);
    of = $random(seed);
    @(posedge pclk);
    offset_load <= 1'b0;
    write_en_n <= 1'b0;
    data_in <= {6'h00, oe};
    @(posedge pclk);
    data_in <= {6'h00, of};
    @(posedge pclk);
    write_en_n <= 1'b1;
    offset_load <= 1'b1;
    apb(1'b0, `FDC_REG_OFS, 32'h0);
    chk("offsets", {4'h0, of, 4'h0, oe}, r);
    apb(1'b1, `FDC_REG_IRQ_CLR, 32'h3F);
    $display("test offsets done");
    for (int p = 0; p < 2; p++) begin
      dly <= (p == 0) ? 4'h9 : 4'h1;
      for (int i = 0; i < 64; i++) begin
        @(posedge pclk);
        w = $random(seed);
        write_en_n <= 1'b0;
        data_in <= w;
        q.push_back(w);
      end
      @(posedge pclk);
      write_en_n <= 1'b1;
      #1;
      chk("full flag", 32'h0, {31'h0, full_flag_n});
      chk("half full", 32'h0, {31'h0, half_full_flag});
      repeat (12) @(posedge pclk);
      chk("write tokens", p + 1, n_wto);
      poke(1'b0);
      apb(1'b0, `FDC_REG_STAT, 32'h0);
      chk("count full", 32'h40, (r >> 16) & 32'h7F);
      apb(1'b0, `FDC_REG_IRQ_ST, 32'h0);
      chk("irq full events", 32'h15, r & 32'h15);
      chk("irq raised", 32'h1, {31'h0, irq});
      apb(1'b1, `FDC_REG_IRQ_CLR, 32'h3F);
      apb(1'b0, `FDC_REG_IRQ_ST, 32'h0);
      chk("irq cleared", 32'h0, r);
      for (int i = 0; i < 64; i++) begin
        // A replay in a chain must not rewind, or the next word would mismatch
        if (i == 32) begin
          @(posedge pclk);
          replay <= 1'b1;
          @(posedge pclk);
          replay <= 1'b0;
        end
        poke(1'b1);
        repeat (2) @(posedge pclk);
        #1;
        chk("read word", {14'h0, q.pop_front()}, {14'h0, data_out});
      end
      chk("empty flag", 32'h0, {31'h0, empty_flag_n});
      repeat (12) @(posedge pclk);
      chk("read tokens", p + 1, n_rto);
      poke(1'b1);
      apb(1'b0, `FDC_REG_IRQ_ST, 32'h0);
      chk("irq empty events", 32'h2A, r & 32'h2A);
      apb(1'b1, `FDC_REG_IRQ_CLR, 32'h3F);
      #1;
      chk("irq low", 32'h0, {31'h0, irq});
      $display("test ring pass %0d done", p);
    end
    apb(1'b1, `FDC_REG_IRQ_EN, 32'h1F);
    poke(1'b1);
    apb(1'b0, `FDC_REG_IRQ_ST, 32'h0);
    chk("refused read event", 32'h20, r & 32'h20);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, `FDC_REG_IRQ_EN, 32'h3F);
    repeat (3) @(posedge pclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    $display("test interrupt mask done");
    give_verdict();
  end
endmodule // tb_fdc_device
